/* rtl/pwe_defs.vh */
// Constants of the power wake event configuration block
`ifndef PWE_DEFS_VH
`define PWE_DEFS_VH
// Register offsets (byte addresses = index * 4)
`define PWE_IDX_SCRATCH1   8'hEC
`define PWE_IDX_SCRATCH2   8'hED
`define PWE_IDX_WAKECTL    8'hEE
`define PWE_IDX_MODE       8'hEF
`define PWE_IDX_IRQ_STAT   8'hF0
`define PWE_IDX_IRQ_EN     8'hF1
`define PWE_IDX_IRQ_CLR    8'hF2
`define PWE_IDX_PIN_EN     8'hF3
// Wake control fields
`define PWE_WC_LOCAL_MASTER_REQ_BIT    7
`define PWE_WC_DMA_BIT     6
`define PWE_WC_NEST_BIT    4
`define PWE_WC_SMI_BIT     0
// Mode fields
`define PWE_MODE_LO        2
`define PWE_MODE_HI        3
`define PWE_MODE_EXTLATCH  2'b11
`define PWE_MODE_DIRECT    2'b00
// Reset values
`define PWE_RST_BYTE       8'h00
// Interrupt status bits
`define PWE_IRQ_WAKE       0
`define PWE_IRQ_ENTER      1
`define PWE_IRQ_STROBE     2
`define PWE_IRQ_W          3
// Strobe width in cycles
`define PWE_STROBE_CYC     4'h4
`endif

/* rtl/pwe_top.v */
// Power wake event configuration registers with wake and strobe logic
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
// Function
// - Two 8-bit scratch bytes, reset to zero, read back last write.
// - Write 1 to wake bit 7, with pin enable bit 0 also set, enables master requests firing strobe.
// - Wake bit 7 reads the woke-up flag; the read clears it.
// - Write-only bit 6 set by 1 enables DMA requests firing strobe.
// - Bit 4 allows nested low-power levels; wake returns to normal.
// - Bit 0 chooses strobe only, or SMI plus strobe on wake, in every mode except 11.
// - Mode 11: always strobe, never drive SMI directly.
// - Mode 00: SMI asserted on entry from normal to low power.
// - Low power: enabled master request wakes, reloads timer, strobes.
`include "pwe_defs.vh"

module pwe_top (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [11:0] wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  input  wire        local_master_req_in,
  input  wire        dma_req_in,
  input  wire        lowpwr_event_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  output reg         power_ctl_strobe_out,
  output reg         system_mgmt_irq_out,
  output reg         low_power_state_out,
  output reg         idle_timer_reload_out,
  output reg         irq_out
);

  // ************************************************
  // Reset release
  // ************************************************
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_b = rst_s2_r;

  // Two-stage release of the asynchronous reset
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  reg [7:0] scratch_byte_one_r;
  reg [7:0] scratch_byte_two_r;
  reg [7:0] wake_source_control_r;
  reg [7:0] sleep_companion_mode_r;
  reg       wake_flag_r;
  reg [`PWE_IRQ_W-1:0] irq_stat_r;
  reg [`PWE_IRQ_W-1:0] irq_en_r;
  reg       local_master_req_detect_en_r;
  reg [1:0] nest_level_r;
  reg [3:0] strobe_cnt_r;

  // Word index decode of a byte address
  function [7:0] pwe_idx;
    input [11:0] adr;
    begin
      pwe_idx = adr[9:2];
    end
  endfunction

  wire       bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire [7:0] idx     = pwe_idx(wb_adr_in);
  wire       wr_lane = bus_req & wb_we_in & wb_sel_in[0];
  wire       rd_acc  = bus_req & ~wb_we_in;
  wire       wr_wake = wr_lane & (idx == `PWE_IDX_WAKECTL);
  wire       rd_wake = rd_acc & (idx == `PWE_IDX_WAKECTL);

  // ************************************************
  // Wake and low-power logic
  // ************************************************
  wire [1:0] mode = sleep_companion_mode_r[`PWE_MODE_HI:`PWE_MODE_LO];
  wire local_master_req_ok = local_master_req_detect_en_r &
                 wake_source_control_r[`PWE_WC_LOCAL_MASTER_REQ_BIT];
  wire dma_ok  = wake_source_control_r[`PWE_WC_DMA_BIT];
  // Wake event only while in low power
  wire wake_ev = low_power_state_out &
                 ((local_master_req_in & local_master_req_ok) |
                  (dma_req_in & dma_ok));
  // Entry allowed from normal, or deeper when nesting is on
  wire nest_on = wake_source_control_r[`PWE_WC_NEST_BIT];
  wire enter_ev = lowpwr_event_in & ~wake_ev &
                  (~low_power_state_out |
                   (nest_on & (nest_level_r != 2'b11)));
  wire first_entry = enter_ev & ~low_power_state_out;
  wire strobe_ev = wake_ev | enter_ev;

  // Power state and nesting depth
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      low_power_state_out <= 1'b0;
      nest_level_r        <= 2'b00;
    end else if (wake_ev) begin
      low_power_state_out <= 1'b0;
      nest_level_r        <= 2'b00;
    end else if (enter_ev) begin
      low_power_state_out <= 1'b1;
      nest_level_r        <= nest_level_r + 2'b01;
    end
  end

  // Strobe, timer reload and system management pulse
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      strobe_cnt_r          <= 4'h0;
      power_ctl_strobe_out  <= 1'b0;
      system_mgmt_irq_out   <= 1'b0;
      idle_timer_reload_out <= 1'b0;
    end else begin
      idle_timer_reload_out <= wake_ev;
      if (strobe_ev) begin
        strobe_cnt_r         <= `PWE_STROBE_CYC;
        power_ctl_strobe_out <= 1'b1;
      end else if (strobe_cnt_r > 4'h1) begin
        strobe_cnt_r <= strobe_cnt_r - 4'h1;
      end else begin
        strobe_cnt_r         <= 4'h0;
        power_ctl_strobe_out <= 1'b0;
      end
      if (mode == `PWE_MODE_EXTLATCH) begin
        system_mgmt_irq_out <= 1'b0;
      end else if (strobe_ev) begin
        system_mgmt_irq_out <=
          ((mode == `PWE_MODE_DIRECT) & first_entry) |
          (wake_source_control_r[`PWE_WC_SMI_BIT] & wake_ev);
      end else if (strobe_cnt_r <= 4'h1) begin
        system_mgmt_irq_out <= 1'b0;
      end
    end
  end

  // ************************************************
  // Register writes
  // ************************************************
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      scratch_byte_one_r     <= `PWE_RST_BYTE;
      scratch_byte_two_r     <= `PWE_RST_BYTE;
      wake_source_control_r  <= `PWE_RST_BYTE;
      sleep_companion_mode_r <= `PWE_RST_BYTE;
      irq_en_r               <= {`PWE_IRQ_W{1'b0}};
      local_master_req_detect_en_r       <= 1'b0;
    end else if (wr_lane) begin
      case (idx)
        `PWE_IDX_SCRATCH1: scratch_byte_one_r <= wb_dat_in[7:0];
        `PWE_IDX_SCRATCH2: scratch_byte_two_r <= wb_dat_in[7:0];
        `PWE_IDX_WAKECTL: begin
          // Bits 7 and 6 only set; zero means no action
          wake_source_control_r[7] <= wake_source_control_r[7] |
                                      wb_dat_in[7];
          wake_source_control_r[6] <= wake_source_control_r[6] |
                                      wb_dat_in[6];
          wake_source_control_r[5:0] <= wb_dat_in[5:0];
        end
        `PWE_IDX_MODE:    sleep_companion_mode_r <= wb_dat_in[7:0];
        `PWE_IDX_IRQ_EN:  irq_en_r <= wb_dat_in[`PWE_IRQ_W-1:0];
        `PWE_IDX_PIN_EN:  local_master_req_detect_en_r <= wb_dat_in[0];
        default: ;
      endcase
    end
  end

  // Wake flag: set wins over clear by read
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      wake_flag_r <= 1'b0;
    end else if (wake_ev) begin
      wake_flag_r <= 1'b1;
    end else if (rd_wake) begin
      wake_flag_r <= 1'b0;
    end
  end

  // ************************************************
  // Interrupt status
  // ************************************************
  wire [`PWE_IRQ_W-1:0] irq_set = {strobe_ev, enter_ev, wake_ev};
  wire [`PWE_IRQ_W-1:0] irq_clr =
    (wr_lane & (idx == `PWE_IDX_IRQ_CLR)) ?
    wb_dat_in[`PWE_IRQ_W-1:0] : {`PWE_IRQ_W{1'b0}};

  // Sticky bits; a new event beats a clear
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= {`PWE_IRQ_W{1'b0}};
      irq_out    <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_out    <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // ************************************************
  // Bus answer
  // ************************************************
  reg [7:0] rd_byte;

  // Read mux; write-only and unmapped read as zero
  always @* begin
    case (idx)
      `PWE_IDX_SCRATCH1: rd_byte = scratch_byte_one_r;
      `PWE_IDX_SCRATCH2: rd_byte = scratch_byte_two_r;
      `PWE_IDX_WAKECTL:  rd_byte = {wake_flag_r, 1'b0,
                                    wake_source_control_r[5:0]};
      `PWE_IDX_MODE:     rd_byte = sleep_companion_mode_r;
      `PWE_IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_r};
      `PWE_IDX_IRQ_EN:   rd_byte = {5'h00, irq_en_r};
      `PWE_IDX_PIN_EN:   rd_byte = {7'h00, local_master_req_detect_en_r};
      default:           rd_byte = 8'h00;
    endcase
  end

  // One wait-free ack per request
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= rd_acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule // pwe_top

/* sim/pwe_top_properties.sv */
// Concurrent checks on the ports of the power wake event block
`timescale 1ns/1ps
module pwe_top_props (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  input wire        power_ctl_strobe_out,
  input wire        system_mgmt_irq_out,
  input wire        low_power_state_out,
  input wire        idle_timer_reload_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Strobe held over its full width
  sequence strobe_run;
    power_ctl_strobe_out [*4];
  endsequence
  // Wake step: reload pulse with strobe, back in normal mode
  sequence wake_step;
    idle_timer_reload_out && power_ctl_strobe_out && !low_power_state_out;
  endsequence
  ack_lat_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=>
    wb_ack_out) else $error("ack not one cycle after request");
  ack_one_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  rd_hi_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 0)
    else $error("read data upper bits not zero");
  strobe_len_a: assert property ($rose(power_ctl_strobe_out) |-> strobe_run)
    else $error("strobe shorter than four cycles");
  reload_wake_a: assert property (idle_timer_reload_out |-> wake_step)
    else $error("reload without wake to normal");
  reload_once_a: assert property (idle_timer_reload_out |=>
    !idle_timer_reload_out) else $error("reload pulse too long");
  fell_reload_a: assert property ($fell(low_power_state_out) |->
    idle_timer_reload_out) else $error("left low power without wake");
  smi_strobe_a: assert property (system_mgmt_irq_out |->
    power_ctl_strobe_out) else $error("irq outside strobe window");
  enter_strb_a: assert property ($rose(low_power_state_out) |->
    power_ctl_strobe_out) else $error("entry without strobe");
endmodule // pwe_top_props

bind pwe_top pwe_top_props u_pwe_top_props (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .power_ctl_strobe_out(power_ctl_strobe_out),
  .system_mgmt_irq_out(system_mgmt_irq_out),
  .low_power_state_out(low_power_state_out),
  .idle_timer_reload_out(idle_timer_reload_out));

/* sim/pwe_far_end.sv */
// Requesters beside the block: bus master, DMA and idle timer
`timescale 1ns/1ps
module pwe_far_end (
  input  wire clk_in,
  output wire local_master_req_out,
  output wire dma_req_out,
  output wire lowpwr_event_out
);
  reg [2:0] req_r = 3'h0;
  // One request line each; one-hot {idle, dma, master}
  assign local_master_req_out = req_r[0];
  assign dma_req_out          = req_r[1];
  assign lowpwr_event_out     = req_r[2];
  // Raise the chosen requests for one cycle
  task pulse(input logic [2:0] w);
    @(posedge clk_in);
    req_r <= w;
    @(posedge clk_in);
    req_r <= 3'h0;
  endtask
endmodule // pwe_far_end

/* sim/pwe_top_tb_top.sv */
// Register and wake event tests of the power wake event block
`timescale 1ns/1ps
`include "pwe_defs.vh"
module pwe_top_tb_top;
  logic clk_in = 0;
  logic rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [11:0] wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic wb_ack_out, strb, smi, lp, reload, irq, local_master_req, dma, lpe;
  logic [7:0]  q;
  int n_errors = 0, num_checks = 0;
  always #20 clk_in = ~clk_in;
  pwe_top u_pwe_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .local_master_req_in(local_master_req), .dma_req_in(dma), .lowpwr_event_in(lpe),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .power_ctl_strobe_out(strb), .system_mgmt_irq_out(smi),
    .low_power_state_out(lp), .idle_timer_reload_out(reload),
    .irq_out(irq));
  pwe_far_end u_pwe_far_end (.clk_in(clk_in), .local_master_req_out(local_master_req),
    .dma_req_out(dma), .lowpwr_event_out(lpe));
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] idx, d,
                    output logic [7:0] rd);
    int n;
    n = 0;
    wb_cyc_in <= 1; wb_stb_in <= 1; wb_we_in <= we;
    wb_adr_in <= {2'b00, idx, 2'b00}; wb_dat_in <= {24'h00_0000, d};
    do begin @(posedge clk_in); n++; end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out[7:0];
    wb_cyc_in <= 0; wb_stb_in <= 0;
    @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #400000;
    n_errors++;
    close_out;
  end
  initial begin
    rst_b_in <= 0; wb_cyc_in <= 0; wb_stb_in <= 0; wb_we_in <= 0;
    wb_adr_in <= 0; wb_sel_in <= 4'h1; wb_dat_in <= 0;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      wb(0, 8'(8'hEC + i), 8'h00, q); chk("reset value", 0, q);
    end
    wb(1, `PWE_IDX_SCRATCH1, 8'hA5, q);
    wb(1, `PWE_IDX_SCRATCH2, 8'h5A, q);
    wb_sel_in <= 4'h0;
    wb(1, `PWE_IDX_SCRATCH1, 8'hFF, q);
    wb_sel_in <= 4'h1;
    wb(0, `PWE_IDX_SCRATCH1, 8'h00, q); chk("scratch1", 8'hA5, q);
    wb(0, `PWE_IDX_SCRATCH2, 8'h00, q); chk("scratch2", 8'h5A, q);
    wb(0, 8'h10, 8'h00, q); chk("unmapped", 0, q);
    // Direct mode: entry raises the management interrupt
    wb(1, `PWE_IDX_IRQ_EN, 8'h07, q);
    wb(1, `PWE_IDX_MODE, 8'h41, q);
    u_pwe_far_end.pulse(3'b100); #1;
    chk("enter lp", 1, lp); chk("enter smi", 1, smi);
    @(posedge clk_in); #1 chk("irq on", 1, irq);
    wb(0, `PWE_IDX_IRQ_STAT, 8'h00, q); chk("status", 8'h06, q);
    wb(1, `PWE_IDX_IRQ_CLR, 8'h07, q); #1 chk("irq off", 0, irq);
    // Master request wakes only with both enables
    u_pwe_far_end.pulse(3'b001); #1 chk("no wake", 1, lp);
    wb(1, `PWE_IDX_PIN_EN, 8'h01, q);
    wb(1, `PWE_IDX_WAKECTL, 8'h80, q);
    u_pwe_far_end.pulse(3'b001); #1;
    chk("wake lp", 0, lp); chk("reload", 1, reload);
    chk("wake strobe", 1, strb); chk("wake smi", 0, smi);
    wb(0, `PWE_IDX_WAKECTL, 8'h00, q); chk("flag set", 8'h80, q);
    wb(0, `PWE_IDX_WAKECTL, 8'h00, q); chk("flag clr", 8'h00, q);
    // Latch mode, nesting and DMA wake
    wb(1, `PWE_IDX_MODE, 8'h4D, q);
    wb(1, `PWE_IDX_WAKECTL, 8'h51, q);
    u_pwe_far_end.pulse(3'b100); #1;
    chk("latch lp", 1, lp); chk("latch strb", 1, strb);
    chk("latch smi", 0, smi);
    wb(1, `PWE_IDX_IRQ_CLR, 8'h07, q);
    u_pwe_far_end.pulse(3'b100); #1 chk("nested", 1, lp);
    wb(0, `PWE_IDX_IRQ_STAT, 8'h00, q); chk("nest enter", 8'h06, q);
    u_pwe_far_end.pulse(3'b010); #1;
    chk("dma wake", 0, lp); chk("dma smi", 0, smi);
    wb(0, `PWE_IDX_WAKECTL, 8'h00, q); chk("wakectl", 8'h91, q);
    // Direct mode with interrupt on wake
    wb(1, `PWE_IDX_MODE, 8'h41, q);
    u_pwe_far_end.pulse(3'b100); #1 chk("enter smi2", 1, smi);
    u_pwe_far_end.pulse(3'b010); #1 chk("wake smi", 1, smi);
    close_out;
  end
endmodule // pwe_top_tb_top
